// file: rtl/daq_scan_timing_sequencer.sv
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "daq_seq_cfg.svh"
module daq_scan_timing_sequencer
  import daq_seq_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // register bus
  input  wire apb_req_t         apb_req,
  output apb_rsp_t              apb_rsp,
  // function pins in
  input  wire logic [`NPIN-1:0] programmable_function_pin_in,
  // timing outputs
  output logic                  posttrigger_event_out,
  output logic                  posttrigger_event_oe,
  output logic                  scan_start_pulse_out,
  output logic                  scan_start_pulse_oe,
  output logic                  convert_out_n,
  output logic                  convert_oe,
  output logic                  adc_convert,
  output logic                  mux_advance_pulse,
  output logic                  external_latch_strobe_n
);

  seq_state_t state_q, state_d;
  logic [`NPIN-1:0] rise, fall;
  logic start_ev, post_raw, post_acc, gate_on, si_tick, int_req, scan_req;
  logic scan_go, conv_go, last, sw_start, sw_stop, stb_go, wr, active;

  // ****************************************
  // pin selection and strobe half period helpers
  // ****************************************
  function automatic logic pick(input logic [`NPIN-1:0] v, input pinsel_t s);
    pick = (s.pin < 4'(`NPIN)) ? v[s.pin] : 1'b0;
  endfunction
  function automatic logic edge_of(input logic [`NPIN-1:0] r, input logic [`NPIN-1:0] f,
                                   input pinsel_t s);
    edge_of = s.pol ? pick(f, s) : pick(r, s);
  endfunction
  function automatic logic [6:0] stb_half(input logic fast);
    stb_half = fast ? 7'(`STB_FAST_HALF - 1) : 7'(`STB_SLOW_HALF - 1);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  // one process holds everything so the cycle order is easy to follow
  always_comb begin
    state_d = state_q;
    // bus: answer one cycle after setup, no further waits
    state_d.rsp.pready  = apb_req.psel & ~apb_req.penable;
    state_d.rsp.pslverr = 1'b0;
    state_d.rsp.prdata  = 32'h0000_0000;
    if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
      if (apb_req.paddr == `OFS_CTRL) begin
        state_d.rsp.prdata = state_q.ctrl;
      end else if (apb_req.paddr == `OFS_PSEL_A) begin
        state_d.rsp.prdata = state_q.psa;
      end else if (apb_req.paddr == `OFS_PSEL_B) begin
        state_d.rsp.prdata = {16'h0000, state_q.psb};
      end else if (apb_req.paddr == `OFS_INTERVAL) begin
        state_d.rsp.prdata = {state_q.samp_iv, state_q.scan_iv};
      end else if (apb_req.paddr == `OFS_SCANS) begin
        state_d.rsp.prdata = {state_q.post_n, state_q.pre_n};
      end else if (apb_req.paddr == `OFS_CONV) begin
        state_d.rsp.prdata = {24'h00_0000, state_q.cps};
      end else if (apb_req.paddr == `OFS_STATUS) begin
        state_d.rsp.prdata = {state_q.scan_cnt, state_q.conv_left, 5'h00,
                              state_q.busy, state_q.acq};
      end else begin
        state_d.rsp.pslverr = 1'b1;
      end
    end
    if (apb_req.psel & ~apb_req.penable & apb_req.pwrite) begin
      state_d.rsp.pslverr = (apb_req.paddr > `OFS_CONV) | (apb_req.paddr[1:0] != 2'h0);
    end
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & state_q.rsp.pready;
    sw_start = wr && apb_req.paddr == `OFS_CTRL && apb_req.pwdata[`BIT_SW_START];
    sw_stop  = wr && apb_req.paddr == `OFS_CTRL && apb_req.pwdata[`BIT_SW_STOP];
    stb_go   = wr && apb_req.paddr == `OFS_CTRL && apb_req.pwdata[`BIT_STB_GO];
    if (wr) begin
      if (apb_req.paddr == `OFS_CTRL) begin
        state_d.ctrl = ctrl_t'(apb_req.pwdata & `CTRL_KEEP); // strobe bits not stored
      end else if (apb_req.paddr == `OFS_PSEL_A) begin
        state_d.psa = apb_req.pwdata;
      end else if (apb_req.paddr == `OFS_PSEL_B) begin
        state_d.psb = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `OFS_INTERVAL) begin
        {state_d.samp_iv, state_d.scan_iv} = apb_req.pwdata;
      end else if (apb_req.paddr == `OFS_SCANS) begin
        {state_d.post_n, state_d.pre_n} = apb_req.pwdata;
      end else if (apb_req.paddr == `OFS_CONV) begin
        state_d.cps = apb_req.pwdata[`CPS_W-1:0];
      end
    end

    // pin synchroniser: level moves only when stages two and three agree
    state_d.s1  = programmable_function_pin_in;
    state_d.s2  = state_q.s1;
    state_d.s3  = state_q.s2;
    state_d.flt = (~(state_q.s2 ^ state_q.s3) & state_q.s3) |
                  ((state_q.s2 ^ state_q.s3) & state_q.flt);
    rise = state_d.flt & ~state_q.flt;
    fall = ~state_d.flt & state_q.flt;

    active   = state_q.acq != ACQ_IDLE;
    start_ev = ~active & (sw_start | edge_of(rise, fall, state_q.psa[0]));
    post_raw = edge_of(rise, fall, state_q.psa[1]);
    post_acc = post_raw & (state_q.acq == ACQ_ARMED) & ~sw_stop;
    gate_on  = pick(state_q.flt, state_q.psb[0]) ^ state_q.psb[0].pol;

    // scan interval clock: level pin edge, fast timebase or 100 kHz divider
    state_d.si_lvl = pick(state_q.flt, state_q.psb[1]) ^ state_q.psb[1].pol;
    state_d.slow_div = (state_q.slow_div == 7'(`SLOW_DIV - 1)) ? 7'h00 : state_q.slow_div + 7'h01;
    if (state_q.ctrl.si_ext) begin
      si_tick = state_d.si_lvl & ~state_q.si_lvl;
    end else if (state_q.ctrl.si_slow) begin
      si_tick = state_q.slow_div == 7'h00;
    end else begin
      si_tick = 1'b1; // fast timebase is capped at the bus clock rate
    end

    // scan interval counter runs only inside a sequence
    int_req = 1'b0;
    if (start_ev) begin
      state_d.si_cnt = state_q.scan_iv;
    end else if (active & si_tick) begin
      if (state_q.si_cnt == '0) begin
        int_req = 1'b1;
        state_d.si_cnt = state_q.scan_iv;
      end else begin
        state_d.si_cnt = state_q.si_cnt - 1'b1;
      end
    end
    scan_req = state_q.ctrl.int_scan ? int_req : edge_of(rise, fall, state_q.psa[2]);
    // gate sampled only when a scan would begin, so a running scan is untouched
    scan_go = scan_req & active & ~state_q.busy & ~gate_on & ~state_q.ctrl.sw_gate &
              ~sw_stop;

    // conversions: internal counter zero or each external edge inside a scan
    if (state_q.ctrl.int_conv) begin
      conv_go = state_q.busy & (state_q.samp_cnt == '0);
    end else begin
      conv_go = state_q.busy & edge_of(rise, fall, state_q.psa[3]);
    end
    conv_go = conv_go & active & ~sw_stop;
    last = conv_go & (state_q.conv_left <= 8'h01);

    // sample interval counter; reload never below one keeps pulses apart
    if (scan_go | conv_go) begin
      state_d.samp_cnt = (state_q.samp_iv == '0) ? 16'h0001 : state_q.samp_iv;
    end else if (state_q.busy) begin
      state_d.samp_cnt = state_q.samp_cnt - 1'b1;
    end
    if (scan_go) begin
      state_d.busy = 1'b1;
      state_d.conv_left = state_q.cps;
    end else if (conv_go) begin
      state_d.conv_left = state_q.conv_left - 1'b1;
    end
    if (last | sw_stop) begin
      state_d.busy = 1'b0;
    end

    // acquisition sequence
    case (state_q.acq)
      ACQ_IDLE: begin
        if (start_ev) begin
          state_d.acq = state_q.ctrl.pretrig ? ACQ_PRE : ACQ_POST;
          state_d.scan_cnt = state_q.ctrl.pretrig ? state_q.pre_n : state_q.post_n;
        end
      end
      ACQ_PRE: begin
        if (state_q.scan_cnt == '0) begin
          state_d.acq = ACQ_ARMED;
          state_d.scan_cnt = state_q.post_n;
        end else if (last) begin
          state_d.scan_cnt = state_q.scan_cnt - 1'b1;
        end
      end
      ACQ_ARMED: begin
        if (post_acc) begin
          state_d.acq = ACQ_POST;
        end
      end
      ACQ_POST: begin
        if (state_q.scan_cnt == '0) begin
          state_d.acq = ACQ_IDLE;
        end else if (last) begin
          state_d.scan_cnt = state_q.scan_cnt - 1'b1;
        end
      end
      default: state_d.acq = ACQ_IDLE;
    endcase
    if (sw_stop) begin
      state_d.acq = ACQ_IDLE;
    end

    // mux advance: one cycle late, four cycles wide
    if (conv_go) begin
      state_d.mux_cnt = 3'(`MUX_DLY_CYC + `MUX_WID_CYC);
    end else if (state_q.mux_cnt != 3'h0) begin
      state_d.mux_cnt = state_q.mux_cnt - 3'h1;
    end

    // latch strobe: eight low pulses at the chosen half period
    if (stb_go & state_q.ctrl.stb_hw & (state_q.stb_left == 5'h00)) begin
      state_d.stb_left = 5'(2 * `STB_PULSES);
      state_d.stb_div  = stb_half(state_q.ctrl.stb_fast);
    end else if (state_q.stb_left != 5'h00) begin
      if (state_q.stb_div == 7'h00) begin
        state_d.stb_div  = stb_half(state_q.ctrl.stb_fast);
        state_d.stb_left = state_q.stb_left - 5'h01;
      end else begin
        state_d.stb_div = state_q.stb_div - 7'h01;
      end
    end

    // registered pin outputs; drivers stay off until software enables them
    state_d.po.post    = post_acc;
    state_d.po.post_oe = state_q.ctrl.oe_post;
    state_d.po.scan    = scan_go | (state_q.ctrl.scan_lvl & state_q.po.scan &
                         state_q.busy & ~last);
    state_d.po.scan_oe = state_q.ctrl.oe_scan;
    state_d.po.conv_n  = ~conv_go;
    state_d.po.conv_oe = state_q.ctrl.oe_conv;
    state_d.po.adc     = conv_go;
    state_d.po.mux     = (state_q.ctrl.mux_en & (state_d.mux_cnt != 3'h0) &
                         (state_d.mux_cnt <= 3'(`MUX_WID_CYC))) ^ state_q.ctrl.mux_pol;
    state_d.po.stb_n   = state_q.ctrl.stb_hw ?
                         ~((state_d.stb_left != 5'h00) & ~state_d.stb_left[0]) :
                         ~state_q.ctrl.stb_level;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= '0;
      state_q.cps       <= `RST_CPS;
      state_q.acq       <= ACQ_IDLE;
      state_q.po.conv_n <= 1'b1;
      state_q.po.stb_n  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the register
  assign apb_rsp                 = state_q.rsp;
  assign posttrigger_event_out   = state_q.po.post;
  assign posttrigger_event_oe    = state_q.po.post_oe;
  assign scan_start_pulse_out    = state_q.po.scan;
  assign scan_start_pulse_oe     = state_q.po.scan_oe;
  assign convert_out_n           = state_q.po.conv_n;
  assign convert_oe              = state_q.po.conv_oe;
  assign adc_convert             = state_q.po.adc;
  assign mux_advance_pulse       = state_q.po.mux;
  assign external_latch_strobe_n = state_q.po.stb_n;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_post_ignored: assert property (post_raw && state_q.acq != ACQ_ARMED |=> !posttrigger_event_out)
    else $error("posttrigger accepted outside armed phase");
  a_post_phase: assert property (posttrigger_event_out |-> state_q.acq == ACQ_POST)
    else $error("posttrigger pulse without posttrigger phase");
  a_post_width: assert property (post_acc |=> posttrigger_event_out ##1 !posttrigger_event_out)
    else $error("posttrigger pulse width wrong");
  a_post_reload: assert property (post_acc |=> state_q.scan_cnt == $past(state_q.post_n))
    else $error("post count not held at trigger");
  a_conv_idle: assert property (state_q.acq == ACQ_IDLE |=> convert_out_n && !adc_convert)
    else $error("conversion outside sequence");
  a_conv_pulse: assert property ($fell(convert_out_n) |=> convert_out_n)
    else $error("conversion pulse longer than one cycle");
  a_gate_hold: assert property (state_q.busy && gate_on && !conv_go && !sw_stop |=> state_q.busy)
    else $error("gate aborted running scan");
  a_gate_mask: assert property ((gate_on || state_q.ctrl.sw_gate) && !state_q.busy
                                |=> !state_q.busy)
    else $error("scan began while gated");
  a_samp_load: assert property (scan_go && state_q.samp_iv > 16'h0001
                                |=> state_q.samp_cnt == $past(state_q.samp_iv))
    else $error("sample counter not loaded at scan start");
  a_mux_shape: assert property (conv_go && state_q.ctrl.mux_en && !state_q.ctrl.mux_pol
                                && state_q.samp_iv > 16'h0004
                                |=> !mux_advance_pulse ##1 mux_advance_pulse[*4]
                                ##1 !mux_advance_pulse)
    else $error("mux advance timing wrong");
  a_stb_count: assert property (stb_go && state_q.ctrl.stb_hw && state_q.stb_left == 5'h00
                                |=> state_q.stb_left == 5'h10)
    else $error("strobe burst not loaded");
  c_pretrig_run: cover property (state_q.acq == ACQ_ARMED ##[1:1000] post_acc);
  c_gated_scan: cover property (scan_req && active && gate_on);
  c_scan_done: cover property (last && state_q.acq == ACQ_POST);

endmodule // daq_scan_timing_sequencer

// file: rtl/daq_seq_cfg.svh
`ifndef DAQ_SEQ_CFG_SVH
`define DAQ_SEQ_CFG_SVH
// ****************************************
// widths
// ****************************************
`define NPIN        10
`define CNT_W       16
`define CPS_W       8
// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL     8'h00
`define OFS_PSEL_A   8'h04
`define OFS_PSEL_B   8'h08
`define OFS_INTERVAL 8'h0C
`define OFS_SCANS    8'h10
`define OFS_CONV     8'h14
`define OFS_STATUS   8'h18
// ****************************************
// field positions and reset values
// ****************************************
`define BIT_SW_START  1
`define BIT_SW_STOP   2
`define BIT_STB_GO    17
`define CTRL_KEEP     32'h0001_FFF9
`define RST_WORD      32'h0000_0000
`define RST_CPS       8'h01
// ****************************************
// timing
// ****************************************
`define PCLK_HZ       10000000
`define PULSE_MIN_NS  50
`define MUX_DLY_NS    50
`define MUX_WID_NS    400
`define SLOW_TB_HZ    100000
`define STB_SLOW_NS   10000
`define STB_FAST_NS   1200
`define STB_PULSES    8
`define NS_CYC_UP(ns) ((((ns) * (`PCLK_HZ / 1000000)) + 999) / 1000)
`define PULSE_CYC     `NS_CYC_UP(`PULSE_MIN_NS)
`define MUX_DLY_CYC   `NS_CYC_UP(`MUX_DLY_NS)
`define MUX_WID_CYC   `NS_CYC_UP(`MUX_WID_NS)
`define SLOW_DIV      (`PCLK_HZ / `SLOW_TB_HZ)
`define STB_SLOW_HALF (`NS_CYC_UP(`STB_SLOW_NS) / 2)
`define STB_FAST_HALF (`NS_CYC_UP(`STB_FAST_NS) / 2)
`endif

// file: rtl/daq_seq_pkg.sv
`include "daq_seq_cfg.svh"
package daq_seq_pkg;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_PRE, ACQ_ARMED, ACQ_POST} acq_state_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic [13:0] rsvd;
    logic stb_go, stb_level, stb_fast, stb_hw, si_ext, si_slow;
    logic oe_conv, oe_scan, oe_post, mux_pol, mux_en, scan_lvl;
    logic int_conv, int_scan, sw_gate, sw_stop, sw_start, pretrig;
  } ctrl_t;
  typedef struct packed {
    logic       pol;
    logic [2:0] rsvd;
    logic [3:0] pin;
  } pinsel_t;
  typedef struct packed {
    logic                post, post_oe, scan, scan_oe;
    logic                conv_n, conv_oe, adc, mux, stb_n;
  } pins_out_t;
  typedef struct packed {
    apb_rsp_t            rsp;
    ctrl_t               ctrl;
    pinsel_t [3:0]       psa;
    pinsel_t [1:0]       psb;
    logic [`CNT_W-1:0]   scan_iv, samp_iv, pre_n, post_n;
    logic [`CPS_W-1:0]   cps;
    logic [`NPIN-1:0]    s1, s2, s3, flt;
    acq_state_t          acq;
    logic [`CNT_W-1:0]   scan_cnt, si_cnt, samp_cnt;
    logic [6:0]          slow_div, stb_div;
    logic                si_lvl, busy;
    logic [`CPS_W-1:0]   conv_left;
    logic [2:0]          mux_cnt;
    logic [4:0]          stb_left;
    pins_out_t           po;
  } seq_state_t;
endpackage

// file: testbench/daq_scan_timing_sequencer_bench.sv
`timescale 1ns/1ps
`include "daq_seq_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", n, e, g); end end
module daq_scan_timing_sequencer_bench
  import daq_seq_pkg::*;
;
  typedef struct { logic [7:0] a; logic [31:0] wd, rv; logic we, re; } row_t;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  apb_req_t         req = '0;
  apb_rsp_t         rsp;
  logic [`NPIN-1:0] pins, fire = '0;
  logic             gate_lvl = 1'b0;
  logic             post_o, post_oe, scan_o, scan_oe, conv_n, conv_oe, adc, mux, stb_n;
  logic             scan_p = 1'b0, stb_p = 1'b1, er;
  logic [31:0]      rd;
  int               bad_count = 0, checks = 0;
  int               n_post, n_scan, n_scyc, n_conv, n_adc, n_mux, n_stb;
  row_t rows [7] = '{'{8'h04, 32'h0302_0100, 32'h0302_0100, 1'b0, 1'b0},
                     '{8'h08, 32'h0000_0504, 32'h0000_0504, 1'b0, 1'b0},
                     '{8'h0C, 32'h0005_0014, 32'h0005_0014, 1'b0, 1'b0},
                     '{8'h10, 32'h0002_0000, 32'h0002_0000, 1'b0, 1'b0},
                     '{8'h14, 32'h0000_0002, 32'h0000_0002, 1'b0, 1'b0},
                     '{8'h18, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b0},
                     '{8'h1C, 32'h1234_5678, 32'h0000_0000, 1'b1, 1'b1}};
  // ****
  // clock, design and far side
  // ****
  always #50 pclk = ~pclk;
  daq_scan_timing_sequencer dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .programmable_function_pin_in(pins),
    .posttrigger_event_out(post_o), .posttrigger_event_oe(post_oe),
    .scan_start_pulse_out(scan_o), .scan_start_pulse_oe(scan_oe),
    .convert_out_n(conv_n), .convert_oe(conv_oe), .adc_convert(adc),
    .mux_advance_pulse(mux), .external_latch_strobe_n(stb_n));
  pin_equip equip (.pclk(pclk), .fire(fire), .gate_lvl(gate_lvl), .pins(pins));
  // ****
  // monitors and tasks
  // ****
  // count events mid-cycle, where registered outputs are settled
  always @(negedge pclk) begin
    n_post += post_o;
    n_scyc += scan_o;
    n_scan += scan_o & !scan_p;
    n_conv += !conv_n;
    n_adc += adc;
    n_mux += mux;
    n_stb += stb_p & !stb_n;
    scan_p = scan_o;
    stb_p = stb_n;
  end
  task automatic clr();
    {n_post, n_scan, n_scyc, n_conv, n_adc, n_mux, n_stb} = '0;
  endtask
  // one apb transfer; pready and the answer are taken at the rising edge itself
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    `CHK("pready", 1'b1, rsp.pready)
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // poll the sequence state with a bounded number of reads
  task automatic st(input logic [1:0] s, input int lim);
    int i;
    i = 0;
    do begin
      xfer(1'b0, `OFS_STATUS, 32'h0);
      i++;
    end while (rd[1:0] !== s && i < lim);
    `CHK("state", s, rd[1:0])
  endtask
  // pulse one function pin, then give the synchroniser time to pass it
  task automatic pulse(input int k);
    @(posedge pclk);
    fire <= (10'h001 << k);
    @(posedge pclk);
    fire <= '0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog reckoned at about ten times the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  // ****
  // main sequence
  // ****
  initial begin
    clr();
    repeat (2) @(posedge pclk);
    `CHK("conv_oe", 1'b0, conv_oe)
    `CHK("post_oe", 1'b0, post_oe)
    `CHK("scan_oe", 1'b0, scan_oe)
    `CHK("conv_n", 1'b1, conv_n)
    presetn <= 1'b1;
    xfer(1'b0, `OFS_CONV, 32'h0);
    `CHK("cps reset", 32'h1, rd)
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].wd);
      `CHK("write err", rows[i].we, er)
      xfer(1'b0, rows[i].a, 32'h0);
      `CHK("read value", rows[i].rv, rd)
      `CHK("read err", rows[i].re, er)
    end
    // internal timing, fast, slow and pin-clocked scan interval; posttrigger only
    for (int m = 0; m < 3; m++) begin
      xfer(1'b1, `OFS_CTRL, 32'hEB0 | ((m == 0) ? 32'h0 : (32'h800 << m)));
      clr();
      xfer(1'b1, `OFS_CTRL, 32'hEB2 | ((m == 0) ? 32'h0 : (32'h800 << m)));
      pulse(1);
      st(2'h0, 3000);
      `CHK("post unused", 0, n_post)
      `CHK("scans", 2, n_scan)
      `CHK("scan pulse", 2, n_scyc)
      `CHK("adc", 4, n_adc)
      `CHK("conv out", 4, n_conv)
      `CHK("mux", 16, n_mux)
    end
    `CHK("conv_oe on", 1'b1, conv_oe)
    `CHK("post_oe on", 1'b1, post_oe)
    `CHK("scan_oe on", 1'b1, scan_oe)
    // pretriggered, level scan output; an early posttrigger is dropped
    xfer(1'b1, `OFS_INTERVAL, 32'h0005_0040);
    xfer(1'b1, `OFS_SCANS, 32'h0001_0001);
    xfer(1'b1, `OFS_CONV, 32'h1);
    xfer(1'b1, `OFS_CTRL, 32'hEF1);
    clr();
    xfer(1'b1, `OFS_CTRL, 32'hEF3);
    pulse(1);
    xfer(1'b0, `OFS_STATUS, 32'h0);
    `CHK("pre state", 2'h1, rd[1:0])
    `CHK("early post", 0, n_post)
    st(2'h2, 500);
    pulse(1);
    `CHK("post out", 1, n_post)
    st(2'h0, 2000);
    `CHK("scan level", 1'b1, n_scyc > n_scan)
    // pin-started, external scan and convert, pin and software gating
    xfer(1'b1, `OFS_SCANS, 32'h0001_0000);
    xfer(1'b1, `OFS_CTRL, 32'hE80);
    clr();
    pulse(0);
    st(2'h3, 5);
    gate_lvl <= 1'b1;
    pulse(2);
    `CHK("gated scan", 0, n_scan)
    gate_lvl <= 1'b0;
    xfer(1'b1, `OFS_CTRL, 32'hE88);
    pulse(2);
    `CHK("sw gated", 0, n_scan)
    xfer(1'b1, `OFS_CTRL, 32'hE80);
    pulse(3);
    `CHK("masked conv", 0, n_conv)
    pulse(2);
    `CHK("ext scan", 1, n_scan)
    gate_lvl <= 1'b1;
    pulse(3);
    `CHK("ext conv", 1, n_adc)
    `CHK("mux ext", 4, n_mux)
    st(2'h0, 50);
    gate_lvl <= 1'b0;
    pulse(3);
    `CHK("idle conv", 1, n_conv)
    // hardware strobe train, then software level
    clr();
    xfer(1'b1, `OFS_CTRL, 32'h0C000);
    xfer(1'b1, `OFS_CTRL, 32'h2C000);
    repeat (150) @(posedge pclk);
    `CHK("strobes", 8, n_stb)
    xfer(1'b1, `OFS_CTRL, 32'h10000);
    repeat (2) @(posedge pclk);
    `CHK("strobe level", 1'b0, stb_n)
    give_verdict();
  end
endmodule // daq_scan_timing_sequencer_bench

// file: testbench/pin_equip.sv
`timescale 1ns/1ps
`include "daq_seq_cfg.svh"
// ****
// far-side trigger, clock and gate equipment
// ****
module pin_equip
  import daq_seq_pkg::*;
(
  // clock
  input  wire logic             pclk,
  // commands from the bench
  input  wire logic [`NPIN-1:0] fire,
  input  wire logic             gate_lvl,
  // function pins
  output logic      [`NPIN-1:0] pins
);
  logic [3:0] cnt_q [`NPIN] = '{default: 4'h0};
  logic [1:0] div_q = 2'h0;
  // a pulse is 2 cycles high; repeats wait 8 cycles for spacing
  always @(posedge pclk) begin
    div_q <= div_q + 2'h1;
    for (int k = 0; k < `NPIN; k++) begin
      if (fire[k] && cnt_q[k] == 4'h0) cnt_q[k] <= 4'h8;
      else if (cnt_q[k] != 4'h0) cnt_q[k] <= cnt_q[k] - 4'h1;
    end
  end
  // pins idle low; pin 4 is the gate level, pin 5 a free clock at pclk/4
  always_comb begin
    for (int k = 0; k < `NPIN; k++) pins[k] = (cnt_q[k] > 4'h6);
    pins[4] = gate_lvl;
    pins[5] = div_q[1];
  end
endmodule // pin_equip
